//--- bench/test_cpu_data_memory_and_status_flags.sv
`timescale 1ns/10ps
module test_cpu_data_memory_and_status_flags;
  import cdm_pkg::*;
  logic sys_clk;
  logic rst;
  cdm_avs_req_type req;
  logic [31:0] rdata;
  logic wait_req;
  logic [7:0] flash_rdata;
  cdm_flash_req_type freq;
  logic [7:0] psw_out;
  int bad_count;
  int compares;
  int fwr_count;
  int fer_count;
  logic [15:0] fwr_addr;
  logic [7:0] fwr_data;
  logic [31:0] v;

  cdm_core u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .avs_req(req),
    .avs_readdata(rdata),
    .avs_waitrequest(wait_req),
    .flash_rdata(flash_rdata),
    .flash_req(freq),
    .psw_out(psw_out)
  );

  // ==========================================
  // Flash stand-in: byte derived from address
  assign flash_rdata = freq.addr[7:0] ^ 8'h5A;

  always @(posedge sys_clk) begin
    if (freq.flash_wr === 1'b1) begin
      fwr_count++;
      fwr_addr = freq.addr;
      fwr_data = freq.data;
    end
    if (freq.flash_erase === 1'b1)
      fer_count++;
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // Tasks
  task automatic end_of_test;
    $display("Counts: %0d compares, %0d bad", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    if (wait_req !== 1'b0) begin
      bad_count++;
      $display("BAD %0t bus answer never came", $time);
      end_of_test;
    end
    v = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(v[7:0], e);
  endtask

  // Command, idle gap for execution, then result read
  task automatic op(input cdm_op_type o, input logic s,
                    input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, ADDR_ACCESS, {4'h0, o, 7'h00, s, a, d});
    repeat (3) @(posedge sys_clk);
    bus(1'b0, ADDR_RESULT, 32'h00000000);
  endtask

  task automatic opc(input cdm_op_type o, input logic s,
                     input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    op(o, s, a, d);
    chk(v[7:0], e);
  endtask

  // Flags masked by m; accumulator checked only when m is C4 (add, subtract and other)
  task automatic ar(input cdm_arith_type k, input logic [7:0] pre,
                    input logic [7:0] a, input logic [7:0] b,
                    input logic [7:0] ea, input logic [7:0] ef,
                    input logic [7:0] m);
    wr(ADDR_PSW, pre);
    wr(ADDR_ACC, a);
    wr(ADDR_BREG, b);
    bus(1'b1, ADDR_ARITH, {13'h0000, k, 8'h00, b});
    repeat (3) @(posedge sys_clk);
    bus(1'b0, ADDR_PSW, 32'h00000000);
    chk(v[7:0] & m, ef);
    if (m == 8'hC4) begin
      rdc(ADDR_ACC, ea);
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    bad_count = 0;
    compares = 0;
    fwr_count = 0;
    fwr_addr = 16'h0000;
    fer_count = 0;
    fwr_data = 8'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(ADDR_PSW, 8'h00);
    rdc(ADDR_SP, 8'h07);
    rdc(8'h20, 8'h00);
    $display("test reset done");

    wr(ADDR_ACC, 8'h07);
    rdc(ADDR_PSW, 8'h01);
    chk(psw_out, 8'h01);
    wr(ADDR_ACC, 8'h03);
    wr(ADDR_PSW, 8'h23);
    rdc(ADDR_PSW, 8'h22);
    op(CDM_OP_BIT_WR, 1'b0, 8'hD5, 8'h00);
    rdc(ADDR_PSW, 8'h02);
    $display("test flags done");

    op(CDM_OP_PUSH, 1'b0, 8'h00, 8'h77);
    rdc(ADDR_SP, 8'h08);
    opc(CDM_OP_DIRECT_RD, 1'b0, 8'h08, 8'h00, 8'h77);
    wr(ADDR_SP, 8'hFE);
    op(CDM_OP_PUSH, 1'b0, 8'h00, 8'h33);
    rdc(ADDR_SP, 8'hFF);
    op(CDM_OP_REG_WR, 1'b0, 8'h00, 8'hFF);
    opc(CDM_OP_IND_RD, 1'b0, 8'h00, 8'h00, 8'h33);
    opc(CDM_OP_POP, 1'b0, 8'h00, 8'h00, 8'h33);
    rdc(ADDR_SP, 8'hFE);
    $display("test stack done");

    ar(CDM_AR_ADD, 8'h44, 8'hFF, 8'h01, 8'h00, 8'hC0, 8'hC4);
    ar(CDM_AR_ADD, 8'h00, 8'h7F, 8'h01, 8'h80, 8'h44, 8'hC4);
    ar(CDM_AR_ADD, 8'hC4, 8'h11, 8'h22, 8'h33, 8'h00, 8'hC4);
    ar(CDM_AR_SUM_WITH_CARRY_INSTRUCTION, 8'h80, 8'h0E, 8'h01, 8'h10, 8'h40, 8'hC4);
    ar(CDM_AR_SUBTRACT_BORROW_INSTRUCTION, 8'h00, 8'h00, 8'h01, 8'hFF, 8'hC0, 8'hC4);
    ar(CDM_AR_SUBTRACT_BORROW_INSTRUCTION, 8'h00, 8'h80, 8'h01, 8'h7F, 8'h44, 8'hC4);
    ar(CDM_AR_SUBTRACT_BORROW_INSTRUCTION, 8'h80, 8'h05, 8'h01, 8'h03, 8'h00, 8'hC4);
    ar(CDM_AR_MUL, 8'h80, 8'h10, 8'h10, 8'h00, 8'h04, 8'h84);
    ar(CDM_AR_MUL, 8'h84, 8'h0F, 8'h11, 8'h00, 8'h00, 8'h84);
    ar(CDM_AR_DIV, 8'h80, 8'h08, 8'h00, 8'h00, 8'h04, 8'h84);
    ar(CDM_AR_DIV, 8'h84, 8'h08, 8'h02, 8'h00, 8'h00, 8'h84);
    ar(CDM_AR_OTHER, 8'hC4, 8'h12, 8'h34, 8'h12, 8'h04, 8'hC4);
    $display("test arithmetic done");

    for (int b = 0; b < 4; b++) begin
      wr(ADDR_PSW, 8'(b << 3));
      op(CDM_OP_REG_WR, 1'b0, 8'h01, 8'(8'hA0 + b));
      opc(CDM_OP_DIRECT_RD, 1'b0, 8'(b * 8 + 1), 8'h00,
          8'(8'hA0 + b));
    end
    op(CDM_OP_REG_WR, 1'b0, 8'h00, 8'h40);
    op(CDM_OP_IND_WR, 1'b0, 8'h00, 8'h5A);
    opc(CDM_OP_DIRECT_RD, 1'b0, 8'h40, 8'h00, 8'h5A);
    op(CDM_OP_REG_WR, 1'b0, 8'h01, 8'h90);
    op(CDM_OP_IND_WR, 1'b1, 8'h00, 8'h3C);
    op(CDM_OP_DIRECT_WR, 1'b0, 8'h90, 8'h11);
    opc(CDM_OP_IND_RD, 1'b1, 8'h00, 8'h00, 8'h3C);
    $display("test banks done");

    op(CDM_OP_DIRECT_WR, 1'b0, 8'h22, 8'h00);
    op(CDM_OP_BIT_WR, 1'b0, 8'h13, 8'h01);
    opc(CDM_OP_DIRECT_RD, 1'b0, 8'h22, 8'h00, 8'h08);
    opc(CDM_OP_BIT_RD, 1'b0, 8'h13, 8'h00, 8'h01);
    op(CDM_OP_DIRECT_WR, 1'b0, 8'h2F, 8'h01);
    op(CDM_OP_BIT_WR, 1'b0, 8'h7F, 8'h01);
    opc(CDM_OP_DIRECT_RD, 1'b0, 8'h2F, 8'h00, 8'h81);
    $display("test bits done");

    wr(ADDR_PSW, 8'h00);
    bus(1'b1, ADDR_DATA_POINTER_16, 32'h00000123);
    bus(1'b0, ADDR_DATA_POINTER_16, 32'h00000000);
    chk(v[15:8], 8'h01);
    chk(v[7:0], 8'h23);
    op(CDM_OP_XDPTR_WR, 1'b0, 8'h00, 8'h9C);
    chk(8'(fwr_count), 8'h00);
    wr(ADDR_EMC, 8'h01);
    op(CDM_OP_REG_WR, 1'b0, 8'h01, 8'h23);
    opc(CDM_OP_XRI_RD, 1'b1, 8'h00, 8'h00, 8'h9C);
    wr(ADDR_CTRL, 8'h01);
    op(CDM_OP_XDPTR_WR, 1'b0, 8'h00, 8'h55);
    chk(8'(fwr_count), 8'h01);
    chk(fwr_addr[15:8], 8'h01);
    chk(fwr_addr[7:0], 8'h23);
    chk(fwr_data, 8'h55);
    wr(ADDR_CTRL, 8'h03);
    op(CDM_OP_XDPTR_WR, 1'b0, 8'h00, 8'hAA);
    chk(8'(fer_count), 8'h01);
    chk(8'(fwr_count), 8'h01);
    wr(ADDR_CTRL, 8'h00);
    opc(CDM_OP_XDPTR_RD, 1'b0, 8'h00, 8'h00, 8'h9C);
    bus(1'b1, ADDR_DATA_POINTER_16, 32'h00000034);
    op(CDM_OP_DIRECT_WR, 1'b0, 8'h34, 8'h00);
    opc(CDM_OP_CODE_RD, 1'b0, 8'h34, 8'h00, 8'h6E);
    bus(1'b1, ADDR_DATA_POINTER_16, 32'h0000FC00);
    opc(CDM_OP_CODE_RD, 1'b0, 8'h00, 8'h00, 8'h00);
    $display("test external done");
    end_of_test;
  end
endmodule

//--- core/cdm_core.sv
`timescale 1ns/10ps
// How it works
// RL1 - Carry set on add carry-out or subtract borrow, else cleared by arithmetic
// RL2 - Nibble carry set on carry into or borrow from high nibble, cleared by other, kept by multiply and divide
// RL3 - Bank select picks working registers 00..03 times eight bytes
// RL4 - Overflow on signed overflow, multiply above 255, divide by zero
// RL5 - Sum, subtract, multiply, divide otherwise clear overflow
// RL6 - Parity bit is read-only odd parity of the accumulator
// RL7 - Two user flags are plain read/write bits, each writable by bit address
// RL8 - 256 bytes of internal RAM at 0x00 through 0xFF
// RL9 - Lower 128 bytes reachable directly and indirectly
// RL10 - Above 0x7F direct writes are dropped and direct reads return 0, indirect hits upper RAM
// RL11 - Bytes 0x00-0x1F are four banks of eight, status bits 3-4 choose
// RL12 - Indirect pointer comes from register zero or one of active bank
// RL13 - Bytes 0x20-0x2F hold 128 bits, address = 8*offset + bit
// RL14 - Bit or byte access chosen by the instruction type
// RL15 - Push writes at pointer plus one then increments pointer
// RL16 - Reset loads stack pointer with 0x07
// RL17 - Stack may sit anywhere in 256 bytes, indirect above 0x7F
// RL18 - Flash contiguous up to lock byte, above it reserved
// RL19 - Code reads read flash; external writes go to RAM unless redirected
// RL20 - Code and data spaces share addresses, instruction type selects
// RL21 - 4096 bytes on-chip external RAM via data pointer or indirect
// RL22 - Indirect external move: high byte from control, low from index
module cdm_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cdm_pkg::cdm_avs_req_type avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] flash_rdata,
  output cdm_pkg::cdm_flash_req_type flash_req,
  output logic [7:0] psw_out
);
  import cdm_pkg::*;

  // ==========================================
  // Storage
  logic [7:0] iram [IRAM_DEPTH]; // RL8
  logic [7:0] on_chip_external_ram [ON_CHIP_EXTERNAL_RAM_DEPTH];
  logic [7:0] psw_store;
  logic [7:0] acc;
  logic [7:0] breg;
  logic [7:0] sp;
  logic [7:0] emc;
  logic [15:0] data_pointer_16;
  logic [1:0] ctrl;
  logic [7:0] result;
  logic [15:0] ares;
  logic busy;
  logic pending;
  logic [31:0] cmd;
  logic [7:0] rdmux;

  // Control bits: [0] flash redirect, [1] erase vs write, large variant tie
  logic large_part;
  assign large_part = 1'b1;

  // ==========================================
  // Helpers
  function automatic logic [7:0] bank_addr(input logic [1:0] bank,
                                           input logic [2:0] idx);
    bank_addr = {3'b000, bank, idx}; // RL3 RL11
  endfunction

  function automatic logic [7:0] bit_byte(input logic [6:0] baddr);
    bit_byte = BIT_BASE + {4'h0, baddr[6:3]}; // RL13
  endfunction

  logic parity;
  assign parity = ^acc; // RL6

  logic [7:0] program_status_word;
  assign program_status_word = {psw_store[7:1], parity};

  wire [1:0] bank = psw_store[PSW_RS1:PSW_RS0];
  wire [3:0] op = cmd[27:24];
  wire [7:0] c_addr = cmd[15:8];
  wire [7:0] c_data = cmd[7:0];
  wire c_sel1 = cmd[16];
  wire [7:0] ptr = iram[bank_addr(bank, {2'b00, c_sel1})]; // RL12
  wire [15:0] xaddr_ri = {emc, ptr}; // RL22
  wire [15:0] lock_addr = large_part ? LOCK_LARGE : LOCK_SMALL;

  // ==========================================
  // Avalon slave: one wait cycle on every access
  wire req = avs_req.read | avs_req.write;
  wire seen = req & avs_waitrequest & ~pending;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      pending <= 1'b0;
    end else begin
      pending <= req & avs_waitrequest & ~pending;
      avs_waitrequest <= ~(req & avs_waitrequest & ~pending);
    end
  end
  wire take = req & ~avs_waitrequest;
  wire wr_take = take & avs_req.write;

  always_comb begin
    unique case (avs_req.address)
      ADDR_PSW: rdmux = program_status_word;
      ADDR_ACC: rdmux = acc;
      ADDR_SP: rdmux = sp;
      ADDR_EMC: rdmux = emc;
      ADDR_CTRL: rdmux = {6'h00, ctrl};
      ADDR_RESULT: rdmux = result;
      ADDR_BREG: rdmux = breg;
      default: rdmux = 8'h00;
    endcase
  end

  // Loaded as waitrequest drops, so data already stands at the ack edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (seen && avs_req.read) begin
      if (avs_req.address == ADDR_DATA_POINTER_16)
        avs_readdata <= {16'h0000, data_pointer_16};
      else if (avs_req.address == ADDR_ARES)
        avs_readdata <= {16'h0000, ares};
      else
        avs_readdata <= {24'h00_0000, rdmux};
    end
  end

  // ==========================================
  // Arithmetic flag update
  wire ar_go = wr_take && avs_req.address == ADDR_ARITH;
  wire [2:0] ar_kind = avs_req.writedata[18:16];
  wire [7:0] opnd = avs_req.writedata[7:0];
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [15:0] prod;
  logic cin;
  always_comb begin
    cin = (ar_kind == CDM_AR_SUM_WITH_CARRY_INSTRUCTION || ar_kind == CDM_AR_SUBTRACT_BORROW_INSTRUCTION) ?
          psw_store[PSW_CY] : 1'b0;
    if (ar_kind == CDM_AR_SUBTRACT_BORROW_INSTRUCTION) begin
      sum9 = {1'b0, acc} - {1'b0, opnd} - {8'h00, cin};
      sum5 = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
      sum5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    end
    prod = acc * breg;
  end
  wire sub = ar_kind == CDM_AR_SUBTRACT_BORROW_INSTRUCTION;
  wire sovf = sub ? ((acc[7] ^ opnd[7]) & (acc[7] ^ sum9[7]))
                  : (~(acc[7] ^ opnd[7]) & (acc[7] ^ sum9[7]));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psw_store <= PSW_RESET;
    end else if (ar_go) begin
      unique case (ar_kind)
        CDM_AR_ADD, CDM_AR_SUM_WITH_CARRY_INSTRUCTION, CDM_AR_SUBTRACT_BORROW_INSTRUCTION: begin
          psw_store[PSW_CY] <= sum9[8]; // RL1
          psw_store[PSW_AC] <= sum5[4]; // RL2
          psw_store[PSW_OV] <= sovf; // RL4 RL5
        end
        CDM_AR_MUL: begin
          psw_store[PSW_CY] <= 1'b0; // RL1
          psw_store[PSW_OV] <= prod > MUL_MAX; // RL4 RL5
        end
        CDM_AR_DIV: begin
          psw_store[PSW_CY] <= 1'b0; // RL1
          psw_store[PSW_OV] <= breg == 8'h00; // RL4 RL5
        end
        default: begin
          psw_store[PSW_CY] <= 1'b0; // RL1
          psw_store[PSW_AC] <= 1'b0; // RL2
        end
      endcase
    end else if (wr_take && avs_req.address == ADDR_PSW) begin
      psw_store <= avs_req.writedata[7:0] & PSW_SW_MASK; // RL7
    end else if (go && op == CDM_OP_BIT_WR && c_addr[7:3] == 5'h1A) begin
      psw_store[c_addr[2:0]] <= c_data[0]; // RL7
      psw_store[PSW_P] <= 1'b0;
    end
  end

  // ==========================================
  // Accumulator, B and arithmetic result
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc <= 8'h00;
      breg <= 8'h00;
      ares <= 16'h0000;
    end else if (ar_go) begin
      ares <= (ar_kind == CDM_AR_MUL) ? prod : {8'h00, sum9[7:0]};
      if (ar_kind != CDM_AR_MUL && ar_kind != CDM_AR_DIV &&
          ar_kind != CDM_AR_OTHER)
        acc <= sum9[7:0];
    end else if (wr_take && avs_req.address == ADDR_ACC) begin
      acc <= avs_req.writedata[7:0];
    end else if (wr_take && avs_req.address == ADDR_BREG) begin
      breg <= avs_req.writedata[7:0];
    end
  end

  // ==========================================
  // Pointer and control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      emc <= EMC_RESET;
      data_pointer_16 <= 16'h0000;
      ctrl <= 2'b00;
    end else if (wr_take) begin
      if (avs_req.address == ADDR_EMC)
        emc <= avs_req.writedata[7:0];
      if (avs_req.address == ADDR_DATA_POINTER_16)
        data_pointer_16 <= avs_req.writedata[15:0];
      if (avs_req.address == ADDR_CTRL)
        ctrl <= avs_req.writedata[1:0];
    end
  end

  // ==========================================
  // Access command executes one cycle after it is taken
  always_ff @(posedge sys_clk) begin
    if (rst)
      cmd <= 32'h0000_0000;
    else if (pending && avs_req.write && avs_req.address == ADDR_ACCESS)
      cmd <= avs_req.writedata | 32'h8000_0000;
    else
      cmd <= 32'h0000_0000;
  end
  wire go = cmd[31];

  // Stack: pre-increment push, post-decrement pop
  always_ff @(posedge sys_clk) begin
    if (rst)
      sp <= SP_RESET; // RL16
    else if (go && op == CDM_OP_PUSH)
      sp <= sp + 8'h01; // RL15
    else if (go && op == CDM_OP_POP)
      sp <= sp - 8'h01;
    else if (wr_take && avs_req.address == ADDR_SP)
      sp <= avs_req.writedata[7:0];
  end

  // Internal RAM: 256 bytes, wraps so the stack spans all of it
  wire [7:0] ind_addr = ptr;
  always_ff @(posedge sys_clk) begin
    if (go) begin
      unique case (op)
        CDM_OP_DIRECT_WR: begin
          if (c_addr < UPPER_BASE)
            iram[c_addr] <= c_data; // RL9 RL10
        end
        CDM_OP_IND_WR: iram[ind_addr] <= c_data; // RL9 RL10 RL12
        CDM_OP_REG_WR: iram[bank_addr(bank, c_addr[2:0])] <= c_data; // RL11
        CDM_OP_BIT_WR: begin
          if (!c_addr[7])
            iram[bit_byte(c_addr[6:0])][c_addr[2:0]] <= c_data[0]; // RL14
        end
        CDM_OP_PUSH: iram[sp + 8'h01] <= c_data; // RL15 RL17
        default: ;
      endcase
    end
  end

  // On-chip external RAM, 12 address bits
  wire x_data_pointer_16 = op == CDM_OP_XDPTR_WR || op == CDM_OP_XDPTR_RD;
  wire [15:0] xaddr = x_data_pointer_16 ? data_pointer_16 : xaddr_ri; // RL21 RL22
  wire x_wr = op == CDM_OP_XDPTR_WR || op == CDM_OP_XRI_WR;
  always_ff @(posedge sys_clk) begin
    if (go && x_wr && !ctrl[0])
      on_chip_external_ram[xaddr[ON_CHIP_EXTERNAL_RAM_AW-1:0]] <= c_data; // RL19 RL21
  end

  // Flash request: code reads always, external writes when redirected
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_req <= '0;
    end else begin
      flash_req.flash_wr <= go && x_wr && ctrl[0] && !ctrl[1] &&
                            xaddr <= lock_addr; // RL18 RL19
      flash_req.flash_erase <= go && x_wr && ctrl[0] && ctrl[1] &&
                               xaddr <= lock_addr; // RL18 RL19
      // Idle address follows the data pointer so code reads see settled data
      flash_req.addr <= (go && x_wr) ? xaddr : data_pointer_16; // RL20
      flash_req.data <= c_data;
    end
  end

  // Read result of the last read access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result <= 8'h00;
    end else if (go) begin
      unique case (op)
        CDM_OP_DIRECT_RD:
          result <= (c_addr < UPPER_BASE) ? iram[c_addr] : 8'h00; // RL10
        CDM_OP_IND_RD: result <= iram[ind_addr]; // RL9 RL10
        CDM_OP_REG_RD: result <= iram[bank_addr(bank, c_addr[2:0])]; // RL3
        CDM_OP_BIT_RD:
          result <= c_addr[7] ? 8'h00 :
            {7'h00, iram[bit_byte(c_addr[6:0])][c_addr[2:0]]}; // RL13 RL14
        CDM_OP_POP: result <= iram[sp]; // RL17
        CDM_OP_XDPTR_RD, CDM_OP_XRI_RD:
          result <= on_chip_external_ram[xaddr[ON_CHIP_EXTERNAL_RAM_AW-1:0]]; // RL21
        CDM_OP_CODE_RD:
          result <= (data_pointer_16 <= lock_addr) ? flash_rdata : 8'h00; // RL18 RL19
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      psw_out <= PSW_RESET;
    else
      psw_out <= program_status_word;
  end

  // ==========================================
  // Checks
  a_sp_reset_value: assert property (@(posedge sys_clk) // RL16
    $fell(rst) |-> sp == SP_RESET) else $error("sp not 07 after reset");
  a_push_inc: assert property (@(posedge sys_clk) disable iff (rst) // RL15
    go && op == CDM_OP_PUSH |=> sp == $past(sp) + 8'h01)
    else $error("push did not increment sp");
  a_parity_live: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    ##1 psw_out[PSW_P] == ^$past(acc))
    else $error("parity wrong");
  a_mul_ovf: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    ar_go && ar_kind == CDM_AR_MUL |=>
      psw_store[PSW_OV] == ($past(prod) > MUL_MAX))
    else $error("mul overflow wrong");
  a_div_zero: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    ar_go && ar_kind == CDM_AR_DIV |=>
      psw_store[PSW_OV] == ($past(breg) == 8'h00))
    else $error("div overflow wrong");
  a_add_carry: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    ar_go && ar_kind == CDM_AR_ADD |=> psw_store[PSW_CY] == $past(sum9[8]))
    else $error("carry wrong");
  a_nibble_carry: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    ar_go && ar_kind == CDM_AR_OTHER |=> !psw_store[PSW_AC])
    else $error("nibble carry not cleared");
  a_wait_one: assert property (@(posedge sys_clk) disable iff (rst)
    req && avs_waitrequest && !pending |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_stands: assert property (@(posedge sys_clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held too long");
  a_pop_dec: assert property (@(posedge sys_clk) disable iff (rst) // RL15
    go && op == CDM_OP_POP |=> sp == $past(sp) - 8'h01)
    else $error("pop did not decrement sp");
  a_push_store: assert property (@(posedge sys_clk) disable iff (rst) // RL15
    go && op == CDM_OP_PUSH |=> iram[sp] == $past(c_data))
    else $error("push byte not at new top");
  a_subtract_borrow_instruction_borrow: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    ar_go && ar_kind == CDM_AR_SUBTRACT_BORROW_INSTRUCTION |=> psw_store[PSW_CY] ==
      ($past(acc) < {1'b0, $past(opnd)} + $past(cin)))
    else $error("borrow wrong");
  a_user_keep: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    ar_go |=> psw_store[PSW_F0] == $past(psw_store[PSW_F0]) &&
      psw_store[PSW_F1] == $past(psw_store[PSW_F1]))
    else $error("arithmetic touched a user flag");
  // Flash side: one-cycle strobes, never past the lock byte
  a_flash_pulse: assert property (@(posedge sys_clk) disable iff (rst) // RL19
    flash_req.flash_wr |=> !flash_req.flash_wr)
    else $error("flash write strobe too long");
  a_on_chip_external_ram_first: assert property (@(posedge sys_clk) disable iff (rst) // RL19
    go && x_wr && !ctrl[0] |=> !flash_req.flash_wr && !flash_req.flash_erase)
    else $error("external write reached flash");
  a_flash_lock: assert property (@(posedge sys_clk) disable iff (rst) // RL18
    flash_req.flash_wr |-> flash_req.addr <= lock_addr)
    else $error("flash write above lock byte");
  a_code_lock: assert property (@(posedge sys_clk) disable iff (rst) // RL18
    go && op == CDM_OP_CODE_RD && data_pointer_16 > lock_addr |=> result == 8'h00)
    else $error("reserved code space returned data");
endmodule

//--- shared/cdm_pkg.sv
package cdm_pkg;
  // ==========================================
  // Register map (word offsets on the Avalon bus)
  localparam logic [7:0] ADDR_PSW = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h01;
  localparam logic [7:0] ADDR_SP = 8'h02;
  localparam logic [7:0] ADDR_EMC = 8'h03;
  localparam logic [7:0] ADDR_DATA_POINTER_16 = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h05;
  localparam logic [7:0] ADDR_ARITH = 8'h06;
  localparam logic [7:0] ADDR_ACCESS = 8'h07;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_ARES = 8'h09;
  localparam logic [7:0] ADDR_BREG = 8'h0A;

  // ==========================================
  // Status word fields
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_P = 0;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] PSW_SW_MASK = 8'hFE;

  // ==========================================
  // Memory map constants
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] EMC_RESET = 8'h00;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] BIT_LAST = 8'h2F;
  localparam int IRAM_DEPTH = 256;
  localparam int ON_CHIP_EXTERNAL_RAM_DEPTH = 4096;
  localparam int ON_CHIP_EXTERNAL_RAM_AW = 12;
  localparam logic [15:0] LOCK_LARGE = 16'hFBFF;
  localparam logic [15:0] LOCK_SMALL = 16'h7FFF;
  localparam logic [15:0] MUL_MAX = 16'h00FF;

  // ==========================================
  // Operation codes in the access command register
  typedef enum logic [3:0] {
    CDM_OP_DIRECT_RD, CDM_OP_DIRECT_WR, CDM_OP_IND_RD, CDM_OP_IND_WR,
    CDM_OP_BIT_RD, CDM_OP_BIT_WR, CDM_OP_PUSH, CDM_OP_POP,
    CDM_OP_XDPTR_RD, CDM_OP_XDPTR_WR, CDM_OP_XRI_RD, CDM_OP_XRI_WR,
    CDM_OP_CODE_RD, CDM_OP_REG_RD, CDM_OP_REG_WR, CDM_OP_NONE
  } cdm_op_type;

  typedef enum logic [2:0] {
    CDM_AR_ADD, CDM_AR_SUM_WITH_CARRY_INSTRUCTION, CDM_AR_SUBTRACT_BORROW_INSTRUCTION, CDM_AR_MUL, CDM_AR_DIV,
    CDM_AR_OTHER
  } cdm_arith_type;

  // Avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } cdm_avs_req_type;

  // Target of a code or external-data access
  typedef struct packed {
    logic flash_wr;
    logic flash_erase;
    logic [15:0] addr;
    logic [7:0] data;
  } cdm_flash_req_type;
endpackage
